// ==== logic/can_message_buffer.sv ====
// One CAN transmit/receive message buffer with a Wishbone register port
//
// Operation
// RULE_01: Time stamp takes timer high byte at identifier
// RULE_02: Received DLC goes into length field
// RULE_03: Host length becomes transmitted DLC
// RULE_04: RTR set sends remote frame, no data
// RULE_05: Up to eight data bytes, bus order
// RULE_06: Reserved word is plain host storage
// RULE_07: Code 0000 takes no part
// RULE_08: Empty buffer becomes full on reception
// RULE_09: Second unread frame sets overrun code
// RULE_10: Read before next frame gives full
// RULE_11: Busy shown at most 20 cycles
// RULE_12: Host ignores busy bit on transmit buffers
// RULE_13: Code 1000 is never scheduled
// RULE_14: 1100 data frame sent once, then 1000
// RULE_15: 1100 remote frame sent, then 0100
// RULE_16: 1010 answers every matching remote frame
// RULE_17: Matching remote request turns 1010 into 1110
// RULE_18: 1110 sent once, then back to 1010
// RULE_19: Upper identifier word holds fourteen top bits
// RULE_20: SRR stored as received on reception
// RULE_21: IDE selects extended or standard format
// RULE_22: Lower identifier word holds ID bits 14..0
// RULE_23: Lower word LSB is RTR in extended
// RULE_24: Standard lower word holds full timer stamp
// RULE_25: Control word read locks out reception
// RULE_26: Stamp 15..8, code 7..4, length 3..0
// RULE_27: Sixteen bytes, fixed word offsets
//
// The Wishbone slave port was left to the implementer.
`include "can_mb_params.svh"

module can_message_buffer
  import can_mb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] dat_i,
  output logic [15:0] dat_o,
  output logic ack_o,
  input wire logic id_start_i,
  input wire logic rx_store_i,
  input wire logic rx_ide_i,
  input wire logic [28:0] rx_id_i,
  input wire logic rx_srr_i,
  input wire logic rx_rtr_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic [63:0] rx_data_i,
  output logic rx_take_o,
  input wire logic remote_hit_i,
  input wire logic tx_done_i,
  output logic tx_req_o,
  output logic tx_ide_o,
  output logic [28:0] tx_id_o,
  output logic tx_rtr_o,
  output logic [3:0] tx_dlc_o,
  output logic [63:0] tx_data_o,
  output logic locked_o
);

  mb_state_t s;
  mb_state_t n;

  logic wb_req;
  logic wb_go;
  logic wb_rd;
  logic wb_wr;
  logic in_buf;
  logic [2:0] idx;
  logic rd_ctrl;
  logic wr_ctrl;
  logic rd_timer;
  logic [3:0] code;
  logic [15:0] up_w;
  logic [15:0] lo_w;
  logic buf_rtr;
  logic rx_code;
  logic accept;
  logic rx_finish;
  logic sent;
  logic [3:0] hw_code;
  logic [15:0] rx_word [`MB_DATA_WORDS];

  // ****************************************
  // Decode
  // ****************************************
  assign wb_req = cyc_i && stb_i;
  assign wb_go = wb_req && !s.ack;
  assign wb_rd = wb_go && !we_i;
  assign wb_wr = wb_go && we_i;
  assign in_buf = !adr_i[`MB_ADR_PAGE];
  assign idx = adr_i[`MB_ADR_IDX_HI:`MB_ADR_IDX_LO];
  assign rd_ctrl = wb_rd && in_buf && idx == `MB_W_CTRL;
  assign wr_ctrl = wb_wr && in_buf && idx == `MB_W_CTRL;
  assign rd_timer = wb_rd && adr_i == `MB_OFS_TIMER;

  assign code = s.word[`MB_W_CTRL][`MB_CODE_HI:`MB_CODE_LO]; // RULE_26
  assign up_w = s.word[`MB_W_ID_UP];
  assign lo_w = s.word[`MB_W_ID_LO];
  assign buf_rtr = up_w[`MB_UP_IDE] ? lo_w[`MB_LO_RTR] : up_w[`MB_UP_STD_RTR]; // RULE_21 RULE_23
  assign rx_code = code == `MB_CODE_EMPTY || code == `MB_CODE_FULL
                   || code == `MB_CODE_OVERRUN;

  // Inactive and transmit codes never take a frame
  // A control read in the same cycle locks first; the frame waits behind the lock
  assign accept = rx_store_i && s.st == ST_IDLE && !s.locked && !rd_ctrl // RULE_07 RULE_25
                  && rx_code;
  assign rx_finish = s.st == ST_FILL && s.busy_cnt == 5'h01;
  assign sent = tx_done_i && s.tx_req; // RULE_13

  // Byte 0 is the first on the bus and sits in the high lane of the first data word
  genvar k;
  generate
    for (k = 0; k < `MB_DATA_WORDS; k++) begin : g_rx_word
      assign rx_word[k] = rx_data_i[63 - 16 * k -: 16]; // RULE_05
    end
  endgenerate

  mb_code_next u_code (
    .code_i(code),
    .rtr_i(buf_rtr),
    .tx_done_i(sent),
    .remote_hit_i(remote_hit_i),
    .rx_finish_i(rx_finish),
    .rx_fresh_i(s.fresh),
    .code_o(hw_code)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [15:0] rd_val;
    logic [15:0] nup;
    logic [15:0] nlo;
    logic nrtr;
    logic [3:0] ncode;
    rd_val = 16'h0000;
    nup = 16'h0000;
    nlo = 16'h0000;
    nrtr = 1'h0;
    ncode = 4'h0;
    n = s;
    n.timer = s.timer + 16'h0001;
    n.ack = wb_go;
    n.rx_take = 1'h0;

    if (id_start_i) begin
      n.stamp = s.timer; // RULE_01
    end

    // Host access; the spare word is plain storage like the rest
    if (in_buf) begin
      rd_val = s.word[idx];
      if (idx == `MB_W_CTRL && s.st == ST_FILL) begin
        rd_val[`MB_CODE_HI:`MB_CODE_LO] = code | `MB_CODE_BUSY_BIT; // RULE_11
      end
    end else if (adr_i == `MB_OFS_TIMER) begin
      rd_val = s.timer;
    end
    n.rdata = wb_rd ? rd_val : 16'h0000;
    if (wb_wr && in_buf) begin
      if (sel_i[1]) begin
        n.word[idx][15:8] = dat_i[15:8]; // RULE_03 RULE_06 RULE_27
      end
      if (sel_i[0]) begin
        n.word[idx][7:0] = dat_i[7:0];
      end
    end

    // A read during a fill neither locks nor counts as reading the new frame
    if (rd_ctrl && rx_code && s.st == ST_IDLE) begin
      n.locked = 1'h1; // RULE_25
      if (code == `MB_CODE_FULL || code == `MB_CODE_OVERRUN) begin
        n.read_seen = 1'h1; // RULE_10
      end
    end
    if (rd_timer) begin
      n.locked = 1'h0;
    end

    // Receive fill
    case (s.st)
      ST_IDLE: begin
        if (accept) begin
          n.st = ST_FILL;
          n.busy_cnt = `MB_BUSY_CYCLES;
          n.fresh = code == `MB_CODE_EMPTY || s.read_seen; // RULE_10
          n.read_seen = 1'h0;
          n.rx_take = 1'h1;
          n.word[`MB_W_CTRL][`MB_STAMP_HI:`MB_STAMP_LO] =
            s.stamp[`MB_STAMP_HI:`MB_STAMP_LO]; // RULE_01
          n.word[`MB_W_CTRL][`MB_LEN_HI:`MB_LEN_LO] = rx_dlc_i; // RULE_02
          if (rx_ide_i) begin
            nup = {rx_id_i[`MB_ID_BASE_HI:`MB_ID_BASE_LO], rx_srr_i, 1'h1,
                   rx_id_i[`MB_ID_MID_HI:`MB_ID_MID_LO]}; // RULE_19 RULE_20 RULE_21
            nlo = {rx_id_i[`MB_ID_EXT_HI:`MB_ID_EXT_LO], rx_rtr_i}; // RULE_22 RULE_23
          end else begin
            nup = {rx_id_i[`MB_ID_BASE_HI:`MB_ID_BASE_LO], rx_rtr_i, 4'h0};
            nlo = s.stamp; // RULE_24
          end
          n.word[`MB_W_ID_UP] = nup;
          n.word[`MB_W_ID_LO] = nlo;
          for (int i = 0; i < `MB_DATA_WORDS; i++) begin
            n.word[int'(`MB_W_DATA0) + i] = rx_word[i]; // RULE_05
          end
        end
      end
      ST_FILL: begin
        n.busy_cnt = s.busy_cnt - 5'h01;
        if (rx_finish) begin
          n.st = ST_IDLE;
          n.fresh = 1'h0;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Transmit completion stamps the buffer like a reception
    if (sent) begin
      n.word[`MB_W_CTRL][`MB_STAMP_HI:`MB_STAMP_LO] =
        s.stamp[`MB_STAMP_HI:`MB_STAMP_LO]; // RULE_01
      if (!up_w[`MB_UP_IDE]) begin
        n.word[`MB_W_ID_LO] = s.stamp; // RULE_24
      end
    end

    // A host write of the control word overrides a hardware code change
    if (!wr_ctrl) begin
      n.word[`MB_W_CTRL][`MB_CODE_HI:`MB_CODE_LO] = hw_code;
    end

    // Transmit view, taken from the state that will be registered
    ncode = n.word[`MB_W_CTRL][`MB_CODE_HI:`MB_CODE_LO];
    nup = n.word[`MB_W_ID_UP];
    nlo = n.word[`MB_W_ID_LO];
    nrtr = nup[`MB_UP_IDE] ? nlo[`MB_LO_RTR] : nup[`MB_UP_STD_RTR];
    n.tx_req = ncode == `MB_CODE_TX_ONCE || ncode == `MB_CODE_TX_SEND; // RULE_13 RULE_16
    n.tx_ide = nup[`MB_UP_IDE]; // RULE_21
    n.tx_rtr = nrtr;
    if (nup[`MB_UP_IDE]) begin
      n.tx_id = {nup[`MB_UP_BASE_HI:`MB_UP_BASE_LO], nup[`MB_UP_MID_HI:`MB_UP_MID_LO],
                 nlo[`MB_LO_EXT_HI:`MB_LO_EXT_LO]}; // RULE_19 RULE_22
    end else begin
      n.tx_id = {nup[`MB_UP_BASE_HI:`MB_UP_BASE_LO], 18'h00000};
    end
    n.tx_dlc = nrtr ? 4'h0 : n.word[`MB_W_CTRL][`MB_LEN_HI:`MB_LEN_LO]; // RULE_03 RULE_04
    for (int j = 0; j < `MB_DATA_WORDS; j++) begin
      n.tx_data[63 - 16 * j -: 16] = n.word[int'(`MB_W_DATA0) + j]; // RULE_05
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end

  assign ack_o = s.ack;
  assign dat_o = s.rdata;
  assign rx_take_o = s.rx_take;
  assign tx_req_o = s.tx_req;
  assign tx_ide_o = s.tx_ide;
  assign tx_id_o = s.tx_id;
  assign tx_rtr_o = s.tx_rtr;
  assign tx_dlc_o = s.tx_dlc;
  assign tx_data_o = s.tx_data;
  assign locked_o = s.locked;

  // ****************************************
  // Checks
  // ****************************************
  localparam int BUSY_LIM = `MB_BUSY_MAX;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_busy_bounded: assert property ($rose(s.st == ST_FILL) |-> ##[1:BUSY_LIM] s.st == ST_IDLE) // RULE_11
    else $error("busy state held too long");

  a_empty_fills: assert property (accept && code == `MB_CODE_EMPTY && !wr_ctrl // RULE_08
      |-> ##[1:BUSY_LIM] (s.st == ST_IDLE && code == `MB_CODE_FULL))
    else $error("empty buffer did not become full");

  a_full_overruns: assert property (accept && code == `MB_CODE_FULL && !s.read_seen // RULE_09
      && !wr_ctrl && !rd_ctrl |-> ##[1:BUSY_LIM] (s.st == ST_IDLE && code == `MB_CODE_OVERRUN))
    else $error("unread full buffer did not overrun");

  a_inactive_quiet: assert property (code == `MB_CODE_INACTIVE |-> !accept ##1 !rx_take_o) // RULE_07
    else $error("inactive buffer took a frame");

  a_lock_blocks: assert property (s.locked && rx_store_i |-> !accept ##1 !rx_take_o) // RULE_25
    else $error("locked buffer took a frame");

  a_remote_nodata: assert property (tx_req_o && tx_rtr_o |-> tx_dlc_o == 4'h0) // RULE_04
    else $error("remote frame offered with data length");

  a_once_done: assert property (sent && code == `MB_CODE_TX_ONCE && !buf_rtr // RULE_14
      && !wr_ctrl |=> code == `MB_CODE_TX_IDLE ##1 !tx_req_o)
    else $error("single data frame did not return to not ready");

  a_remote_arm: assert property (remote_hit_i && code == `MB_CODE_TX_AUTO // RULE_17
      && !buf_rtr && !wr_ctrl |=> code == `MB_CODE_TX_SEND ##1 tx_req_o)
    else $error("remote request did not schedule response");

  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_lock_sets: assert property (rd_ctrl && rx_code && s.st == ST_IDLE |=> locked_o) // RULE_25
    else $error("control word read did not lock");

  a_busy_shown: assert property (rd_ctrl && s.st == ST_FILL // RULE_11
      |=> dat_o[`MB_CODE_LO] && !locked_o)
    else $error("read during fill not shown busy");

  a_len_stored: assert property (accept // RULE_02
      |=> s.word[`MB_W_CTRL][`MB_LEN_HI:`MB_LEN_LO] == $past(rx_dlc_i))
    else $error("received length not stored");

  a_remote_empty: assert property (sent && code == `MB_CODE_TX_ONCE && buf_rtr // RULE_15
      && !wr_ctrl && !rx_finish |=> code == `MB_CODE_EMPTY)
    else $error("remote request did not become empty receive");

  a_resp_done: assert property (sent && code == `MB_CODE_TX_SEND && !wr_ctrl // RULE_18
      && !rx_finish |=> code == `MB_CODE_TX_AUTO)
    else $error("response did not return to auto answer");

  a_stamp_taken: assert property (id_start_i |=> s.stamp == $past(s.timer)) // RULE_01
    else $error("timer not captured at identifier start");

  a_take_pulse: assert property (rx_take_o |=> !rx_take_o)
    else $error("take held longer than one cycle");

endmodule

// ==== logic/can_mb_params.svh ====
// Offsets, field positions, codes and timing counts of one CAN message buffer
`ifndef CAN_MB_PARAMS_SVH
`define CAN_MB_PARAMS_SVH

// ****************************************
// Byte offsets on the register bus
// ****************************************
`define MB_OFS_TIMER 5'h10
`define MB_ADR_PAGE 4
`define MB_ADR_IDX_HI 3
`define MB_ADR_IDX_LO 1

// ****************************************
// Word indices inside the buffer
// ****************************************
`define MB_W_CTRL 3'h0
`define MB_W_ID_UP 3'h1
`define MB_W_ID_LO 3'h2
`define MB_W_DATA0 3'h3
`define MB_DATA_WORDS 4

// ****************************************
// Control/status word fields
// ****************************************
`define MB_STAMP_HI 15
`define MB_STAMP_LO 8
`define MB_CODE_HI 7
`define MB_CODE_LO 4
`define MB_LEN_HI 3
`define MB_LEN_LO 0

// ****************************************
// Identifier word fields
// ****************************************
`define MB_UP_BASE_HI 15
`define MB_UP_BASE_LO 5
`define MB_UP_SRR 4
`define MB_UP_STD_RTR 4
`define MB_UP_IDE 3
`define MB_UP_MID_HI 2
`define MB_UP_MID_LO 0
`define MB_LO_EXT_HI 15
`define MB_LO_EXT_LO 1
`define MB_LO_RTR 0
`define MB_ID_BASE_HI 28
`define MB_ID_BASE_LO 18
`define MB_ID_MID_HI 17
`define MB_ID_MID_LO 15
`define MB_ID_EXT_HI 14
`define MB_ID_EXT_LO 0

// ****************************************
// Buffer codes
// ****************************************
`define MB_CODE_INACTIVE 4'h0
`define MB_CODE_EMPTY 4'h4
`define MB_CODE_FULL 4'h2
`define MB_CODE_OVERRUN 4'h6
`define MB_CODE_BUSY_BIT 4'h1
`define MB_CODE_TX_IDLE 4'h8
`define MB_CODE_TX_ONCE 4'hC
`define MB_CODE_TX_AUTO 4'hA
`define MB_CODE_TX_SEND 4'hE

// ****************************************
// Timing
// ****************************************
`define MB_BUSY_MAX 20
`define MB_BUSY_CYCLES 5'h04

`endif

// ==== logic/can_mb_pkg.sv ====
// Types of the CAN message buffer: fill states and the packed state record
package can_mb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FILL = 2'b10
  } fill_state_t;

  typedef struct packed {
    fill_state_t st;
    logic [7:0][15:0] word;
    logic [15:0] timer;
    logic [15:0] stamp;
    logic [4:0] busy_cnt;
    logic locked;
    logic read_seen;
    logic fresh;
    logic ack;
    logic [15:0] rdata;
    logic rx_take;
    logic tx_req;
    logic tx_ide;
    logic [28:0] tx_id;
    logic tx_rtr;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data;
  } mb_state_t;

endpackage

// ==== logic/mb_code_next.sv ====
// Hardware transitions of the message buffer code field
`include "can_mb_params.svh"

module mb_code_next (
  input wire logic [3:0] code_i,
  input wire logic rtr_i,
  input wire logic tx_done_i,
  input wire logic remote_hit_i,
  input wire logic rx_finish_i,
  input wire logic rx_fresh_i,
  output logic [3:0] code_o
);

  always_comb begin
    code_o = code_i;
    if (rx_finish_i) begin
      // A read since the last frame turns an overrun back into full
      if (rx_fresh_i) begin
        code_o = `MB_CODE_FULL; // RULE_08 RULE_10 RULE_11
      end else if (code_i == `MB_CODE_FULL || code_i == `MB_CODE_OVERRUN) begin
        code_o = `MB_CODE_OVERRUN; // RULE_09 RULE_11
      end
    end else begin
      case (code_i)
        `MB_CODE_TX_ONCE: begin
          if (tx_done_i) begin
            code_o = rtr_i ? `MB_CODE_EMPTY : `MB_CODE_TX_IDLE; // RULE_14 RULE_15
          end
        end
        `MB_CODE_TX_AUTO: begin
          if (remote_hit_i && !rtr_i) begin
            code_o = `MB_CODE_TX_SEND; // RULE_16 RULE_17
          end
        end
        `MB_CODE_TX_SEND: begin
          if (tx_done_i) begin
            code_o = `MB_CODE_TX_AUTO; // RULE_16 RULE_18
          end
        end
        default: begin
          code_o = code_i;
        end
      endcase
    end
  end

endmodule

// ==== sim/can_bus_engine.sv ====
// Bus-side engine model: offers received frames, remote hits and send completions
module can_bus_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic take_i,
  input wire logic req_i,
  output logic id_start_o,
  output logic store_o,
  output logic ide_o,
  output logic [28:0] id_o,
  output logic srr_o,
  output logic rtr_o,
  output logic [3:0] dlc_o,
  output logic [63:0] data_o,
  output logic hit_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] tick;
  logic [15:0] stamp;

  // Own copy of the free-running timer, so stamps are predicted, never copied
  always @(posedge clk_i) tick <= rst_i ? 16'h0000 : tick + 16'h0001;

  initial begin
    {id_start_o, store_o, ide_o, id_o, srr_o, rtr_o, dlc_o, data_o, hit_o, done_o} = '0;
  end

  task automatic rx_frame(input logic ide, input logic [28:0] id, input logic rtr,
                          input logic [3:0] dlc, input logic [63:0] data, input int lim,
                          output logic took);
    int n;
    n = 0;
    took = 1'h0;
    @(posedge clk_i);
    id_start_o <= 1'h1;
    @(posedge clk_i);
    stamp = tick;
    id_start_o <= 1'h0;
    store_o <= 1'h1;
    ide_o <= ide;
    id_o <= id;
    srr_o <= 1'h1;
    rtr_o <= rtr;
    dlc_o <= dlc;
    data_o <= data;
    while (!took && n < lim) begin
      @(posedge clk_i);
      took = (take_i === 1'h1);
      n++;
    end
    // Released fields flip so a stale value can never pass for a fresh one
    store_o <= 1'h0;
    ide_o <= ~ide;
    id_o <= ~id;
    srr_o <= 1'h0;
    rtr_o <= ~rtr;
    dlc_o <= ~dlc;
    data_o <= ~data;
  endtask

  task automatic hit();
    @(posedge clk_i);
    hit_o <= 1'h1;
    @(posedge clk_i);
    hit_o <= 1'h0;
  endtask

  // Completion only for a frame that was really offered
  task automatic send();
    @(posedge clk_i);
    done_o <= (req_i === 1'h1);
    @(posedge clk_i);
    done_o <= 1'h0;
  endtask
endmodule

// ==== sim/can_message_buffer_tb.sv ====
// Self-checking bench of one CAN message buffer and its bus-side engine
module can_message_buffer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [28:0] ID_EXT = 29'h0ABCDEF5;
  localparam logic [28:0] ID_STD = 29'h1F5C0000;
  localparam logic [28:0] ID_TX = 29'h12345678;
  localparam logic [63:0] D_RX = 64'h0123456789ABCDEF;
  localparam logic [63:0] D_TX = 64'hFEDCBA9876543210;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [4:0] adr = 5'h00;
  logic [1:0] sel = 2'h0;
  logic [15:0] dat = 16'h0000;
  logic [15:0] q;
  logic [15:0] dat_o;
  logic ack_o, rx_take, tx_req, tx_ide, tx_rtr, locked, took;
  logic [28:0] tx_id;
  logic [3:0] tx_dlc;
  logic [63:0] tx_data;
  logic id_start, store, ide, srr, rtr, hit, done;
  logic [28:0] id;
  logic [3:0] dlc;
  logic [63:0] data;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  can_message_buffer can_message_buffer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .id_start_i(id_start),
    .rx_store_i(store), .rx_ide_i(ide), .rx_id_i(id), .rx_srr_i(srr), .rx_rtr_i(rtr),
    .rx_dlc_i(dlc), .rx_data_i(data), .rx_take_o(rx_take), .remote_hit_i(hit),
    .tx_done_i(done), .tx_req_o(tx_req), .tx_ide_o(tx_ide), .tx_id_o(tx_id),
    .tx_rtr_o(tx_rtr), .tx_dlc_o(tx_dlc), .tx_data_o(tx_data), .locked_o(locked)
  );
  can_bus_engine can_bus_engine_inst (
    .clk_i(clk_i), .rst_i(rst_i), .take_i(rx_take), .req_i(tx_req), .id_start_o(id_start),
    .store_o(store), .ide_o(ide), .id_o(id), .srr_o(srr), .rtr_o(rtr), .dlc_o(dlc),
    .data_o(data), .hit_o(hit), .done_o(done)
  );

  always #12.5 clk_i = ~clk_i;

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [1:0] s,
                    input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    // No assumed latency: only the bench timeout ends a lost answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'h1);
    q = dat_o;
    // A write answers with zero data
    chk(w ? q : 16'h0000, 16'h0000);
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    wb(1'h1, a, 2'h3, d);
  endtask

  task automatic rd(input logic [4:0] a);
    wb(1'h0, a, 2'h3, 16'h0000);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_idle();
    rd(5'h00);
    chk(q, 16'h0000);
    can_bus_engine_inst.rx_frame(1'h1, ID_EXT, 1'h0, 4'h8, D_RX, 12, took);
    chk({took, tx_req}, 2'h0);
    wr(5'h0E, 16'hA5C3);
    wb(1'h1, 5'h0E, 2'h2, 16'h7E00);
    rd(5'h0E);
    chk(q, 16'h7EC3);
    rd(5'h12);
    chk(q, 16'h0000);
  endtask

  task automatic sc_rx();
    wr(5'h00, 16'h0040);
    can_bus_engine_inst.rx_frame(1'h1, ID_EXT, 1'h0, 4'h8, D_RX, 30, took);
    chk(took, 1'h1);
    rd(5'h00);
    chk({q[7:4], locked}, 5'h0A);
    repeat (6) @(posedge clk_i);
    rd(5'h00);
    chk(q, {can_bus_engine_inst.stamp[15:8], 8'h28});
    chk(locked, 1'h1);
    rd(5'h02);
    chk(q, {ID_EXT[28:18], 2'h3, ID_EXT[17:15]});
    rd(5'h04);
    chk(q, {ID_EXT[14:0], 1'h0});
    for (int i = 0; i < 4; i++) begin
      rd(5'(6 + 2 * i));
      chk(q, D_RX[63 - 16 * i -: 16]);
    end
    can_bus_engine_inst.rx_frame(1'h0, ID_STD, 1'h0, 4'h3, D_TX, 12, took);
    chk(took, 1'h0);
    rd(5'h10);
    chk(q + 16'h0001, can_bus_engine_inst.tick);
    @(posedge clk_i);
    chk(locked, 1'h0);
    can_bus_engine_inst.rx_frame(1'h0, ID_STD, 1'h0, 4'h3, D_TX, 30, took);
    repeat (6) @(posedge clk_i);
    rd(5'h02);
    chk(q, {ID_STD[28:18], 5'h00});
    rd(5'h04);
    chk(q, can_bus_engine_inst.stamp);
    rd(5'h00);
    chk(q, {can_bus_engine_inst.stamp[15:8], 8'h23});
    rd(5'h10);
    can_bus_engine_inst.rx_frame(1'h1, ID_EXT, 1'h0, 4'h8, D_RX, 30, took);
    can_bus_engine_inst.rx_frame(1'h1, ID_EXT, 1'h1, 4'h0, D_RX, 30, took);
    repeat (6) @(posedge clk_i);
    rd(5'h00);
    chk(q, {can_bus_engine_inst.stamp[15:8], 8'h60});
    rd(5'h10);
  endtask

  task automatic sc_tx();
    wr(5'h02, {ID_TX[28:18], 2'h3, ID_TX[17:15]});
    wr(5'h04, {ID_TX[14:0], 1'h0});
    for (int i = 0; i < 4; i++) wr(5'(6 + 2 * i), D_TX[63 - 16 * i -: 16]);
    wr(5'h00, 16'h0085);
    chk(tx_req, 1'h0);
    wr(5'h00, 16'h00C5);
    chk({tx_req, tx_ide, tx_id, tx_rtr, tx_dlc}, {2'h3, ID_TX, 5'h05});
    chk(tx_data, D_TX);
    can_bus_engine_inst.send();
    rd(5'h00);
    chk({q[7:4] & 4'hE, tx_req}, 5'h10);
    wr(5'h04, {ID_TX[14:0], 1'h1});
    wr(5'h00, 16'h00C5);
    chk({tx_req, tx_rtr, tx_dlc}, 6'h30);
    can_bus_engine_inst.send();
    rd(5'h00);
    chk(q[7:4] & 4'hE, 4'h4);
    rd(5'h10);
    wr(5'h04, {ID_TX[14:0], 1'h0});
    wr(5'h00, 16'h00A5);
    for (int k = 0; k < 2; k++) begin
      chk(tx_req, 1'h0);
      can_bus_engine_inst.hit();
      repeat (2) @(posedge clk_i);
      chk(tx_req, 1'h1);
      can_bus_engine_inst.send();
      rd(5'h00);
      chk(q[7:4] & 4'hE, 4'hA);
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    sc_idle();
    sc_rx();
    sc_tx();
    give_verdict();
  end
endmodule
